// *** hdl/pin_sync.v ***
`timescale 1ns/1ps
// two-stage synchroniser for pins from outside the ref_clk domain
module pin_sync #(
  parameter WIDTH = 1
) (
  input wire ref_clk,
  input wire rst_n,
  input wire [WIDTH-1:0] d,
  output wire [WIDTH-1:0] q
);
  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= {WIDTH{1'b0}};
      sync_ff <= {WIDTH{1'b0}};
    end else begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end
  assign q = sync_ff;
endmodule // pin_sync

// *** hdl/vid_link_rx.v ***
`timescale 1ns/1ps
`include "vr_pin_defs.vh"
// shifts command bits on rising edges of the synchronised link clock
module vid_link_rx (
  input wire ref_clk,
  input wire rst_n,
  input wire link_rst,
  input wire clk_s,
  input wire dat_s,
  output reg cmd_valid_ff,
  output reg [`CMD_BITS-1:0] cmd_ff
);
  reg clk_d_ff;
  reg [`CMD_BITS-1:0] shift_ff;
  reg [3:0] cnt_ff;
  wire rise = clk_s & ~clk_d_ff;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_d_ff <= 1'b0;
      shift_ff <= {`CMD_BITS{1'b0}};
      cnt_ff <= 4'h0;
      cmd_valid_ff <= 1'b0;
      cmd_ff <= {`CMD_BITS{1'b0}};
    end else if (link_rst) begin
      clk_d_ff <= clk_s;
      shift_ff <= {`CMD_BITS{1'b0}};
      cnt_ff <= 4'h0;
      cmd_valid_ff <= 1'b0;
      cmd_ff <= {`CMD_BITS{1'b0}};
    end else begin
      clk_d_ff <= clk_s;
      cmd_valid_ff <= 1'b0;
      if (rise) begin
        shift_ff <= {shift_ff[`CMD_BITS-2:0], dat_s};
        if (cnt_ff == `CMD_BITS - 1) begin
          cnt_ff <= 4'h0;
          cmd_ff <= {shift_ff[`CMD_BITS-2:0], dat_s};
          cmd_valid_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff + 4'h1;
        end
      end
    end
  end
endmodule // vid_link_rx

// *** hdl/vr_pin_control.v ***
`timescale 1ns/1ps
`include "vr_pin_defs.vh"
// What this block does
// - deepest state on all used rails drives primary driver enable low
// - deepest state on all used rails floats the alternate driver enable
// - rail A unused when phase1 sense tied high
// - lowest tied phase n gives n-1 phases
// - rail B unused when its phase1 sense tied
// - link reset returns link logic to defaults
// - overcurrent flag on protection or warning threshold
// - one overcurrent flag shared by both rails
// - thermal warning pulls flag low, regulator keeps running
// - rail A enable high; toggle clears faults only
// - rail B enable high; toggle clears faults only
// - rail A power good low on shutdown fault
// - reference off when shut down or all deep
// - address strap at supply plus enable: solder check
// - I2C address comes from address strap resistor
// - rail B power good low on shutdown fault
module vr_pin_control (
  input wire ref_clk,
  input wire rst_n,
  input wire [3:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  input wire wb_we_i,
  input wire [3:0] wb_sel_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  output reg wb_ack_o,
  input wire vid_link_clock,
  input wire vid_command_line,
  input wire telemetry_in,
  output reg telemetry_out,
  input wire link_reset_n,
  input wire rail_a_enable,
  input wire rail_b_enable,
  input wire [7:0] rail_a_sense_tied,
  input wire rail_b_phase1_sense_tied,
  input wire addr_strap_at_supply,
  input wire [2:0] addr_strap_code,
  input wire oc_prot_a,
  input wire oc_prot_b,
  input wire oc_warn_a,
  input wire oc_warn_b,
  input wire temp_warn,
  input wire shutdown_fault_a,
  input wire shutdown_fault_b,
  output reg driver_enable_primary,
  output wire driver_enable_floatable_o,
  output wire driver_enable_floatable_oe,
  output wire overcurrent_flag_n_o,
  output reg overcurrent_flag_n_oe,
  output wire thermal_warning_n_o,
  output reg thermal_warning_n_oe,
  output wire rail_a_power_good_o,
  output reg rail_a_power_good_oe,
  output wire rail_b_power_good_o,
  output reg rail_b_power_good_oe,
  output reg vref_enable,
  output reg rail_a_run,
  output reg rail_b_run,
  output reg [3:0] rail_a_phase_count,
  output reg solder_check_mode,
  output reg [11:0] rail_a_fixed_mv,
  output reg [11:0] rail_b_fixed_mv,
  output reg [6:0] i2c_address,
  output reg rail_a_fault_clear,
  output reg rail_b_fault_clear
);
  // one synchroniser bank for every pin; bit position of each pin in it
  localparam NSYNC = 24;
  localparam P_HOT = 0;
  localparam P_OC = 1;
  localparam P_CODE = 5;
  localparam P_STRAP_HI = 8;
  localparam P_TIED_B = 9;
  localparam P_TIED_A = 10;
  localparam P_EN_B = 18;
  localparam P_EN_A = 19;
  localparam P_LINK_RST = 20;
  localparam P_TEL = 21;
  localparam P_DAT = 22;
  localparam P_CLK = 23;
  localparam ST_WAIT = 2'b01;
  localparam ST_HELD = 2'b10;

  wire [NSYNC-1:0] raw_pins;
  wire [NSYNC-1:0] pins_s;
  assign raw_pins = {vid_link_clock, vid_command_line, telemetry_in, link_reset_n,
                     rail_a_enable, rail_b_enable, rail_a_sense_tied, rail_b_phase1_sense_tied,
                     addr_strap_at_supply, addr_strap_code, oc_prot_a, oc_prot_b, oc_warn_a,
                     oc_warn_b, temp_warn};
  pin_sync #(.WIDTH(NSYNC)) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .d(raw_pins),
    .q(pins_s)
  );
  wire clk_s = pins_s[P_CLK];
  wire dat_s = pins_s[P_DAT];
  wire tel_s = pins_s[P_TEL];
  wire link_rst = ~pins_s[P_LINK_RST];
  wire en_a_s = pins_s[P_EN_A];
  wire en_b_s = pins_s[P_EN_B];
  wire [7:0] tied_a_s = pins_s[P_TIED_A+7:P_TIED_A];
  wire tied_b_s = pins_s[P_TIED_B];
  wire strap_hi_s = pins_s[P_STRAP_HI];
  wire [2:0] strap_code_s = pins_s[P_CODE+2:P_CODE];
  // protection and warning thresholds of both rails share one flag
  wire oc_any_s = |pins_s[P_OC+3:P_OC];
  wire hot_s = pins_s[P_HOT];
  // fault inputs come from on-chip protection logic in this clock domain
  wire fault_a = shutdown_fault_a;
  wire fault_b = shutdown_fault_b;

  // lowest tied phase among 2..8 sets the count; none tied runs all eight
  function [3:0] phase_decode;
    input [7:0] tied;
    integer i;
    reg found;
    begin
      phase_decode = 4'h8;
      found = 1'b0;
      for (i = 1; i < 8; i = i + 1) begin
        if (tied[i] && !found) begin
          phase_decode = i[3:0];
          found = 1'b1;
        end
      end
    end
  endfunction

  // one-shot strap capture
  reg [1:0] strap_st_ff;
  reg [2:0] strap_cnt_ff;
  reg rail_a_used_ff;
  reg rail_b_used_ff;
  reg [3:0] phases_ff;
  reg [2:0] addr_code_ff;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_st_ff <= ST_WAIT;
      strap_cnt_ff <= 3'h0;
      rail_a_used_ff <= 1'b0;
      rail_b_used_ff <= 1'b0;
      phases_ff <= 4'h0;
      addr_code_ff <= 3'h0;
    end else begin
      case (strap_st_ff)
        ST_WAIT: begin
          // wait past the synchroniser depth so pins are settled
          if (strap_cnt_ff == `STRAP_WAIT) begin
            rail_a_used_ff <= ~tied_a_s[0];
            rail_b_used_ff <= ~tied_b_s;
            phases_ff <= phase_decode(tied_a_s);
            addr_code_ff <= strap_code_s;
            strap_st_ff <= ST_HELD;
          end else begin
            strap_cnt_ff <= strap_cnt_ff + 3'h1;
          end
        end
        ST_HELD: strap_st_ff <= ST_HELD;
        default: strap_st_ff <= ST_WAIT;
      endcase
    end
  end
  wire straps_done = strap_st_ff[1];

  // link command receiver
  wire cmd_valid;
  wire [`CMD_BITS-1:0] cmd;
  vid_link_rx u_rx (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .link_rst(link_rst),
    .clk_s(clk_s),
    .dat_s(dat_s),
    .cmd_valid_ff(cmd_valid),
    .cmd_ff(cmd)
  );
  // opcode in the upper nibble; mask bit 0 is rail A, bit 1 rail B
  reg deep_a_ff;
  reg deep_b_ff;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      deep_a_ff <= 1'b0;
      deep_b_ff <= 1'b0;
    end else if (link_rst) begin
      deep_a_ff <= 1'b0;
      deep_b_ff <= 1'b0;
    end else if (cmd_valid) begin
      if (cmd[7:4] == `OP_DEEP_ENTER) begin
        deep_a_ff <= deep_a_ff | cmd[0];
        deep_b_ff <= deep_b_ff | cmd[1];
      end else if (cmd[7:4] == `OP_DEEP_EXIT) begin
        deep_a_ff <= deep_a_ff & ~cmd[0];
        deep_b_ff <= deep_b_ff & ~cmd[1];
      end
    end
  end
  // an unused rail counts as already parked
  wire all_deep = (deep_a_ff | ~rail_a_used_ff) & (deep_b_ff | ~rail_b_used_ff) &
                  (deep_a_ff | deep_b_ff);

  // enable edges clear active faults; sticky bits are untouched here
  reg en_a_d_ff;
  reg en_b_d_ff;
  reg flt_a_ff;
  reg flt_b_ff;
  wire tog_a = en_a_s ^ en_a_d_ff;
  wire tog_b = en_b_s ^ en_b_d_ff;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_a_d_ff <= 1'b0;
      en_b_d_ff <= 1'b0;
      flt_a_ff <= 1'b0;
      flt_b_ff <= 1'b0;
    end else begin
      en_a_d_ff <= en_a_s;
      en_b_d_ff <= en_b_s;
      // a fault in the clearing cycle still latches
      flt_a_ff <= fault_a | (flt_a_ff & ~tog_a);
      flt_b_ff <= fault_b | (flt_b_ff & ~tog_b);
    end
  end

  // software registers
  reg [31:0] ctrl_ff;
  reg [3:0] sticky_ff;
  // ack is registered, so each request is answered on the next edge and then dropped
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr_en = wb_req & wb_we_i;
  wire shutdown = ctrl_ff[`CTRL_SHUTDOWN_BIT];
  wire [3:0] sticky_set = {hot_s, oc_any_s, fault_b, fault_a};
  reg [3:0] sticky_clr;
  always @* begin
    sticky_clr = 4'h0;
    if (wr_en && wb_adr_i == `REG_STICKY && wb_sel_i[0])
      sticky_clr = wb_dat_i[3:0];
  end
  // status bits show the flags active high, as the pins are being pulled
  reg [31:0] status_word;
  always @* begin
    status_word = 32'h0000_0000;
    status_word[0] = straps_done;
    status_word[1] = thermal_warning_n_oe;
    status_word[2] = overcurrent_flag_n_oe;
    status_word[3] = rail_a_run;
    status_word[4] = rail_b_run;
    status_word[5] = flt_a_ff;
    status_word[6] = flt_b_ff;
    status_word[7] = deep_a_ff;
    status_word[8] = deep_b_ff;
    status_word[9] = driver_enable_primary;
    status_word[10] = vref_enable;
    status_word[11] = solder_check_mode;
  end
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= `CTRL_RESET;
      sticky_ff <= 4'h0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      sticky_ff <= sticky_set | (sticky_ff & ~sticky_clr);
      if (wr_en && wb_adr_i == `REG_CTRL && wb_sel_i[0])
        ctrl_ff[7:0] <= wb_dat_i[7:0];
      // reads of unmapped offsets return zero; writes there are dropped
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `REG_CTRL: wb_dat_o <= ctrl_ff;
          `REG_STATUS: wb_dat_o <= status_word;
          `REG_STICKY: wb_dat_o <= {28'h0, sticky_ff};
          `REG_STRAP: wb_dat_o <= {16'h0, 1'b0, i2c_address, 2'h0, rail_b_used_ff,
                                   rail_a_used_ff, phases_ff};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // pin-side outputs, all registered
  // power good stays low while the straps are still being taken
  wire good_a = en_a_s & ~flt_a_ff & rail_a_used_ff & straps_done & ~shutdown;
  wire good_b = en_b_s & ~flt_b_ff & rail_b_used_ff & straps_done & ~shutdown;
  wire solder = strap_hi_s & en_a_s & straps_done;
  reg float_oe_ff;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      telemetry_out <= 1'b0;
      driver_enable_primary <= 1'b0;
      float_oe_ff <= 1'b1;
      overcurrent_flag_n_oe <= 1'b0;
      thermal_warning_n_oe <= 1'b0;
      rail_a_power_good_oe <= 1'b1;
      rail_b_power_good_oe <= 1'b1;
      vref_enable <= 1'b0;
      rail_a_run <= 1'b0;
      rail_b_run <= 1'b0;
      rail_a_phase_count <= 4'h0;
      solder_check_mode <= 1'b0;
      rail_a_fixed_mv <= 12'h000;
      rail_b_fixed_mv <= 12'h000;
      i2c_address <= 7'h00;
      rail_a_fault_clear <= 1'b0;
      rail_b_fault_clear <= 1'b0;
    end else begin
      // telemetry is forwarded three samples after the pin (two sync stages plus this register), well inside a link bit
      telemetry_out <= link_rst ? 1'b0 : tel_s;
      driver_enable_primary <= straps_done & ~shutdown & ~all_deep;
      float_oe_ff <= ~all_deep;
      overcurrent_flag_n_oe <= oc_any_s;
      // regulation is not gated by the thermal warning
      thermal_warning_n_oe <= hot_s;
      rail_a_power_good_oe <= ~good_a;
      rail_b_power_good_oe <= ~good_b;
      vref_enable <= straps_done & ~shutdown & ~all_deep;
      rail_a_run <= good_a & ~deep_a_ff;
      rail_b_run <= good_b & ~deep_b_ff;
      rail_a_phase_count <= rail_a_used_ff ? phases_ff : 4'h0;
      solder_check_mode <= solder;
      rail_a_fixed_mv <= solder ? `SOLDER_A_MV : 12'h000;
      rail_b_fixed_mv <= solder ? `SOLDER_B_MV : 12'h000;
      // the strap resistor arrives already digitised; its code offsets the base
      i2c_address <= `I2C_ADDR_BASE + {4'h0, addr_code_ff};
      rail_a_fault_clear <= tog_a & flt_a_ff;
      rail_b_fault_clear <= tog_b & flt_b_ff;
    end
  end
  assign driver_enable_floatable_o = driver_enable_primary;
  assign driver_enable_floatable_oe = float_oe_ff;
  assign overcurrent_flag_n_o = 1'b0;
  assign thermal_warning_n_o = 1'b0;
  assign rail_a_power_good_o = 1'b0;
  assign rail_b_power_good_o = 1'b0;
endmodule // vr_pin_control

// *** hdl/vr_pin_defs.vh ***
`ifndef VR_PIN_DEFS_VH
`define VR_PIN_DEFS_VH
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_STICKY 4'h8
`define REG_STRAP 4'hC
`define CTRL_RESET 32'h0000_0000
`define CTRL_SHUTDOWN_BIT 0
`define STICKY_A_BIT 0
`define STICKY_B_BIT 1
`define STICKY_OC_BIT 2
`define STICKY_HOT_BIT 3
`define CMD_BITS 8
`define OP_DEEP_ENTER 4'h3
`define OP_DEEP_EXIT 4'h4
`define SOLDER_A_MV 12'h384
`define SOLDER_B_MV 12'h3E8
`define I2C_ADDR_BASE 7'h60
`define STRAP_WAIT 3'h3
`endif

// *** testbench/tb.sv ***
`timescale 1ns/1ps
`include "vr_pin_defs.vh"
module tb;
  reg ref_clk = 0, rst_n = 0, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0, telemetry_in = 0, link_reset_n = 1;
  reg [3:0] wb_adr_i = 0, wb_sel_i = 0;
  reg [31:0] wb_dat_i = 0;
  reg rail_a_enable = 1, rail_b_enable = 1, rail_b_phase1_sense_tied = 0, addr_strap_at_supply = 0;
  reg [7:0] rail_a_sense_tied = 0;
  reg [2:0] addr_strap_code = 0;
  reg oc_prot_a = 0, oc_prot_b = 0, oc_warn_a = 0, oc_warn_b = 0, temp_warn = 0;
  reg shutdown_fault_a = 0, shutdown_fault_b = 0;
  wire vid_link_clock, vid_command_line, wb_ack_o, telemetry_out, driver_enable_primary;
  wire [31:0] wb_dat_o;
  wire driver_enable_floatable_o, driver_enable_floatable_oe, overcurrent_flag_n_o, overcurrent_flag_n_oe;
  wire thermal_warning_n_o, thermal_warning_n_oe, rail_a_power_good_o, rail_a_power_good_oe;
  wire rail_b_power_good_o, rail_b_power_good_oe, vref_enable, rail_a_run, rail_b_run, solder_check_mode;
  wire rail_a_fault_clear, rail_b_fault_clear;
  wire [3:0] rail_a_phase_count;
  wire [11:0] rail_a_fixed_mv, rail_b_fixed_mv;
  wire [6:0] i2c_address;
  integer fails = 0, n_checks = 0, n, k;
  reg [31:0] q;
  vr_pin_control vr_pin_control_i (.*);
  vid_host vid_host_i (.link_clk(vid_link_clock), .link_dat(vid_command_line));
  always #2 ref_clk = ~ref_clk;
  task chk(input string nm, input [31:0] e, input [31:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task tick(input integer k);
    repeat (k) @(posedge ref_clk);
  endtask
  task wb(input [3:0] a, input w, input [31:0] d);
    @(posedge ref_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'h3, w, 4'hF};
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge ref_clk); while (wb_ack_o !== 1'h1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask
  // straps are only taken after a reset, so every strap setting needs one
  task do_reset(input [7:0] t, input [2:0] c);
    rail_a_sense_tied <= t;
    addr_strap_code <= c;
    rst_n <= 1'h0;
    tick(4);
    rst_n <= 1'h1;
    tick(12);
  endtask
  task t_straps;
    for (n = 1; n <= 9; n++) begin
      do_reset(n == 9 ? 8'h00 : 8'hFF << (n - 1), n[2:0]);
      chk("phases", n == 9 ? 8 : n - 1, rail_a_phase_count);
      chk("a_run", n != 1, rail_a_run);
      chk("i2c", 7'h60 + n[2:0], i2c_address);
    end
    rail_a_sense_tied <= 8'h02;
    tick(10);
    chk("held", 8, rail_a_phase_count);
    rail_b_phase1_sense_tied <= 1'h1;
    do_reset(8'h00, 3'h5);
    chk("b_run", 0, rail_b_run);
    rail_b_phase1_sense_tied <= 1'h0;
    do_reset(8'h00, 3'h5);
    wb(4'hC, 1'h0, 0);
    chk("strap_reg", {17'h0, 7'h65, 8'h38}, q & 32'h7F3F);
    $display("t_straps done");
  endtask
  task t_flags;
    for (n = 0; n < 4; n++) begin
      {oc_prot_a, oc_prot_b, oc_warn_a, oc_warn_b} <= 4'h8 >> n;
      tick(6);
      chk("oc_on", 1, overcurrent_flag_n_oe);
      chk("oc_level", 0, overcurrent_flag_n_o);
      {oc_prot_a, oc_prot_b, oc_warn_a, oc_warn_b} <= 4'h0;
      tick(6);
      chk("oc_off", 0, overcurrent_flag_n_oe);
    end
    temp_warn <= 1'h1;
    tick(6);
    chk("hot", 1, thermal_warning_n_oe);
    chk("a_run_hot", 1, rail_a_run);
    chk("hot_level", 0, thermal_warning_n_o);
    wb(4'h4, 1'h0, 0);
    chk("status_hot", 1, q[1]);
    temp_warn <= 1'h0;
    $display("t_flags done");
  endtask
  task t_fault;
    for (n = 0; n < 2; n++) begin
      {shutdown_fault_b, shutdown_fault_a} <= n ? 2'h2 : 2'h1;
      tick(1);
      {shutdown_fault_b, shutdown_fault_a} <= 2'h0;
      tick(6);
      chk("pg_low", 1, n ? rail_b_power_good_oe : rail_a_power_good_oe);
      {rail_b_enable, rail_a_enable} <= n ? 2'h1 : 2'h2;
      k = 0;
      repeat (5) begin
        @(posedge ref_clk);
        if ((n ? rail_b_fault_clear : rail_a_fault_clear) === 1'h1) k++;
      end
      chk("clr_pulse", 1, k);
      {rail_b_enable, rail_a_enable} <= 2'h3;
      tick(6);
      chk("pg_back", 0, n ? rail_b_power_good_oe : rail_a_power_good_oe);
      wb(4'h8, 1'h0, 0);
      chk("sticky", 1, q[n]);
      wb(4'h8, 1'h1, 32'h3);
      wb(4'h8, 1'h0, 0);
      chk("sticky_clr", 0, q[n]);
    end
    $display("t_fault done");
  endtask
  task t_link;
    vid_host_i.send({`OP_DEEP_ENTER, 4'h3});
    tick(10);
    chk("drv_deep", 0, driver_enable_primary);
    chk("float_deep", 0, driver_enable_floatable_oe);
    chk("vref_deep", 0, vref_enable);
    vid_host_i.send({`OP_DEEP_EXIT, 4'h3});
    tick(10);
    chk("drv_exit", 1, driver_enable_primary);
    chk("float_exit", 1, driver_enable_floatable_oe);
    chk("float_val", 1, driver_enable_floatable_o);
    vid_host_i.send({`OP_DEEP_ENTER, 4'h3});
    tick(10);
    link_reset_n <= 1'h0;
    telemetry_in <= 1'h1;
    tick(8);
    chk("tel_rst", 0, telemetry_out);
    chk("drv_rst", 1, driver_enable_primary);
    link_reset_n <= 1'h1;
    tick(8);
    chk("tel_fwd", 1, telemetry_out);
    $display("t_link done");
  endtask
  task t_ctrl;
    wb(4'h0, 1'h1, 32'h1);
    tick(4);
    chk("vref_off", 0, vref_enable);
    chk("pg_off", 1, rail_a_power_good_oe);
    chk("pg_level", 0, rail_a_power_good_o);
    wb(4'h0, 1'h1, 32'h0);
    tick(4);
    chk("vref_on", 1, vref_enable);
    addr_strap_at_supply <= 1'h1;
    tick(6);
    chk("solder", 1, solder_check_mode);
    chk("mv_a", 12'h384, rail_a_fixed_mv);
    chk("mv_b", 12'h3E8, rail_b_fixed_mv);
    rail_a_enable <= 1'h0;
    tick(6);
    chk("solder_en", 0, solder_check_mode);
    rail_a_enable <= 1'h1;
    tick(6);
    addr_strap_at_supply <= 1'h0;
    $display("t_ctrl done");
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    t_straps;
    t_flags;
    t_fault;
    t_link;
    t_ctrl;
    tally_and_finish;
  end
  initial begin
    #100000 fails++;
    tally_and_finish;
  end
endmodule // tb

// *** testbench/vid_host.sv ***
`timescale 1ns/1ps
module vid_host (
  output reg link_clk,
  output reg link_dat
);
  initial begin
    link_clk = 1'h0;
    link_dat = 1'h0;
  end
  // clock idles low between frames; data shows the inverse of the last bit there
  task automatic send(input [7:0] c);
    integer i;
    for (i = 7; i >= 0; i--) begin
      link_dat = c[i];
      #40 link_clk = 1'h1;
      #40 link_clk = 1'h0;
    end
    link_dat = ~c[0];
  endtask
endmodule // vid_host

// *** testbench/vr_pin_monitor.sv ***
`timescale 1ns/1ps
`include "vr_pin_defs.vh"
module vr_pin_monitor (
  input wire ref_clk,
  input wire rst_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire oc_prot_a,
  input wire oc_prot_b,
  input wire oc_warn_a,
  input wire oc_warn_b,
  input wire overcurrent_flag_n_oe,
  input wire temp_warn,
  input wire thermal_warning_n_oe,
  input wire shutdown_fault_a,
  input wire shutdown_fault_b,
  input wire rail_a_power_good_oe,
  input wire rail_b_power_good_oe,
  input wire driver_enable_primary,
  input wire driver_enable_floatable_oe,
  input wire vref_enable,
  input wire solder_check_mode,
  input wire [11:0] rail_a_fixed_mv,
  input wire [11:0] rail_b_fixed_mv,
  input wire rail_a_run,
  input wire [3:0] rail_a_phase_count
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire oc_any = oc_prot_a | oc_prot_b | oc_warn_a | oc_warn_b;
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_pulse; wb_ack_o ##1 !wb_ack_o; endsequence
  property p_ack; s_req |=> s_pulse; endproperty
  // four stable samples cover the two sync stages plus the flag register
  property p_oc_on; oc_any [*4] |-> overcurrent_flag_n_oe; endproperty
  property p_oc_off; !oc_any [*4] |-> !overcurrent_flag_n_oe; endproperty
  property p_hot; temp_warn [*4] |-> thermal_warning_n_oe; endproperty
  property p_hot_off; !temp_warn [*4] |-> !thermal_warning_n_oe; endproperty
  property p_pga; shutdown_fault_a |-> ##[1:3] rail_a_power_good_oe; endproperty
  property p_pgb; shutdown_fault_b |-> ##[1:3] rail_b_power_good_oe; endproperty
  property p_deep; !driver_enable_floatable_oe |-> !driver_enable_primary && !vref_enable; endproperty
  property p_solder;
    solder_check_mode |-> ##[0:1] (rail_a_fixed_mv == `SOLDER_A_MV && rail_b_fixed_mv == `SOLDER_B_MV);
  endproperty
  property p_strap; rail_a_run && $past(rail_a_run) |-> $stable(rail_a_phase_count); endproperty
  a_ack: assert property (p_ack) else $error("ack not a single pulse after request");
  a_oc_on: assert property (p_oc_on) else $error("overcurrent flag not pulled");
  a_oc_off: assert property (p_oc_off) else $error("overcurrent flag pulled without cause");
  a_hot: assert property (p_hot) else $error("thermal flag not pulled");
  a_hot_off: assert property (p_hot_off) else $error("thermal flag pulled without cause");
  a_pga: assert property (p_pga) else $error("rail a power good not low on fault");
  a_pgb: assert property (p_pgb) else $error("rail b power good not low on fault");
  a_deep: assert property (p_deep) else $error("floating enable while drivers or ref on");
  a_solder: assert property (p_solder) else $error("solder check targets wrong");
  a_strap: assert property (p_strap) else $error("phase count changed while running");
endmodule // vr_pin_monitor
bind vr_pin_control vr_pin_monitor vr_pin_monitor_i (
  .ref_clk(ref_clk),
  .rst_n(rst_n),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o),
  .oc_prot_a(oc_prot_a),
  .oc_prot_b(oc_prot_b),
  .oc_warn_a(oc_warn_a),
  .oc_warn_b(oc_warn_b),
  .overcurrent_flag_n_oe(overcurrent_flag_n_oe),
  .temp_warn(temp_warn),
  .thermal_warning_n_oe(thermal_warning_n_oe),
  .shutdown_fault_a(shutdown_fault_a),
  .shutdown_fault_b(shutdown_fault_b),
  .rail_a_power_good_oe(rail_a_power_good_oe),
  .rail_b_power_good_oe(rail_b_power_good_oe),
  .driver_enable_primary(driver_enable_primary),
  .driver_enable_floatable_oe(driver_enable_floatable_oe),
  .vref_enable(vref_enable),
  .solder_check_mode(solder_check_mode),
  .rail_a_fixed_mv(rail_a_fixed_mv),
  .rail_b_fixed_mv(rail_b_fixed_mv),
  .rail_a_run(rail_a_run),
  .rail_a_phase_count(rail_a_phase_count)
);
